// ### rsp_map.svh
// Command codes, field positions, reset values and defaults of the rail sequencer
// Operation
// - Runtime writes to pin and mode settings change only the stored image.
// - Bit 0 per output picks soft-start input (0) or power-good output (1).
// - Soft-start input mode ignores internal ramp rate and enables 5 uA source.
// - Power-good output mode drives the pin with that output's power good.
// - Sequencing bit 0 clear waits on prior power good; set skips it.
// - Outputs in first start position never wait on power good.
// - Sequencing bit is one device-wide value, independent of page.
// - Stop position bits 3:2, start position bits 1:0, codes 00..11, default 00.
// - Outputs sharing one position start together and stop together.
// - Sequence positions are held per output, pages 0x00 to 0x03.
// - Mode bit 0: 1 continuous conduction, 0 mixed; default 1.
// - Read-only mode bit 1 shows current sharing, only on master pages.
// - Pairs 0/1 and 2/3 share; slave page invalid, slave follows master at 180 degrees.
// - Frequency bits 1:0 divide oscillator by 1, 2, 4 or 8; default 00.
// - Bits 6:2 set phase delay 0..31 quarter oscillator periods.
// - Phase defaults 00000, 00010, 00001, 00011 for pages 0 to 3.
// - Sharing detected sets the indication bit of the pair's master.
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH

// ****************************************
// Command codes
// ****************************************
`define RSP_CMD_PIN 8'hD3
`define RSP_CMD_SEQ 8'hD4
`define RSP_CMD_ORD 8'hD5
`define RSP_CMD_MODE 8'hD6
`define RSP_CMD_FREQ 8'hD7

// ****************************************
// Fields and defaults
// ****************************************
`define RSP_PAGES 8'h04
`define RSP_SEL_BIT 0
`define RSP_CCM_BIT 0
`define RSP_SHARE_BIT 1
`define RSP_START_LSB 0
`define RSP_STOP_LSB 2
`define RSP_DIV_LSB 0
`define RSP_PH_LSB 2
`define RSP_PIN_RST 1'b0
`define RSP_SEQ_RST 1'b0
`define RSP_ORD_RST 4'h0
`define RSP_CCM_RST 1'b1
`define RSP_DIV_RST 2'h0
`define RSP_PH_P0 5'h00
`define RSP_PH_P1 5'h02
`define RSP_PH_P2 5'h01
`define RSP_PH_P3 5'h03
`define RSP_HALF_TURN 5'h02
`define RSP_LAST_POS 2'h3

`endif

// ### rsp_pkg.sv
// Types of the rail sequencer: state enumeration and state record
package rsp_pkg;

   typedef enum logic [1:0] {
      RSP_S_LOAD,
      RSP_S_IDLE,
      RSP_S_START,
      RSP_S_STOP
   } rsp_state_t;

   typedef struct packed {
      rsp_state_t st;
      logic [1:0] step;
      logic seq_ign;
      logic [3:0] pin_s;
      logic [3:0][3:0] ord_s;
      logic [3:0] ccm_s;
      logic [3:0][6:0] frq_s;
      logic [3:0] pin_a;
      logic [3:0] ccm_a;
      logic [3:0][6:0] frq_a;
      logic [3:0] en;
      logic [3:0] ss_src;
      logic [3:0] pg_out;
      logic [3:0] pg_oe;
      logic [3:0] ccm_o;
      logic [3:0][1:0] div_o;
      logic [3:0][4:0] ph_o;
      logic [7:0] rdata;
      logic ack;
      logic err;
      logic busy;
   } rsp_state_rec_t;

endpackage

// ### rsp_core.sv
// Paged configuration registers and start/stop sequencer for four switching outputs
`timescale 1ns/1ns
`include "rsp_map.svh"

module rsp_core (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_cmd_i,
   input wire logic [7:0] reg_page_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic nv_stored_i,
   input wire logic [3:0] nv_pin_i,
   input wire logic nv_seq_i,
   input wire logic [15:0] nv_ord_i,
   input wire logic [3:0] nv_ccm_i,
   input wire logic [27:0] nv_frq_i,
   input wire logic [1:0] share_det_i,
   input wire logic [3:0] power_good_i,
   input wire logic seq_start_i,
   input wire logic seq_stop_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_ack_o,
   output logic reg_err_o,
   output logic [3:0] rail_en_o,
   output logic [3:0] softstart_src_en_o,
   output logic [3:0] output_pwrgood_pin_o,
   output logic [3:0] output_pwrgood_pin_oe_o,
   output logic [3:0] conduction_mode_o,
   output logic [7:0] clk_div_o,
   output logic [19:0] phase_delay_o,
   output logic seq_busy_o
);

   rsp_pkg::rsp_state_rec_t r_reg;
   rsp_pkg::rsp_state_rec_t r_next;

   // ****************************************
   // Sharing helpers
   // ****************************************
   // Set when output p is the slave page of a pair that is sharing
   function automatic logic is_slave(input logic [1:0] p, input logic [1:0] det);
      is_slave = p[0] && det[p[1]];
   endfunction

   // Output whose settings output p follows
   function automatic logic [1:0] src_of(input logic [1:0] p, input logic [1:0] det);
      src_of = is_slave(p, det) ? {p[1], 1'b0} : p;
   endfunction

   // Outputs whose start or stop position equals pos
   function automatic logic [3:0] group_at(input logic [3:0][3:0] ord,
                                           input logic [1:0] det,
                                           input logic [1:0] pos,
                                           input logic stop);
      logic [3:0] g;
      logic [3:0] o;
      g = 4'h0;
      for (int p = 0; p < 4; p++) begin
         o = ord[src_of(p[1:0], det)];
         if (stop) begin
            g[p] = (o[`RSP_STOP_LSB+:2] == pos);
         end else begin
            g[p] = (o[`RSP_START_LSB+:2] == pos);
         end
      end
      group_at = g;
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [1:0] pg;
      logic [1:0] s;
      logic page_ok;
      logic [3:0] grp;
      logic [4:0] ph;
      logic [1:0] dv;
      pg = reg_page_i[1:0];
      s = 2'h0;
      page_ok = (reg_page_i < `RSP_PAGES) && !is_slave(reg_page_i[1:0], share_det_i);
      grp = 4'h0;
      ph = 5'h00;
      dv = 2'h0;
      r_next = r_reg;
      r_next.ack = 1'b0;
      r_next.err = 1'b0;

      unique case (r_reg.st)
         rsp_pkg::RSP_S_LOAD: begin
            // Stored image, or defaults if never stored
            for (int p = 0; p < 4; p++) begin
               if (nv_stored_i) begin
                  r_next.pin_s[p] = nv_pin_i[p];
                  r_next.ord_s[p] = nv_ord_i[4*p+:4];
                  r_next.ccm_s[p] = nv_ccm_i[p];
                  r_next.frq_s[p] = nv_frq_i[7*p+:7];
               end else begin
                  r_next.pin_s[p] = `RSP_PIN_RST;
                  r_next.ord_s[p] = `RSP_ORD_RST;
                  r_next.ccm_s[p] = `RSP_CCM_RST;
               end
            end
            if (!nv_stored_i) begin
               r_next.frq_s[0] = {`RSP_PH_P0, `RSP_DIV_RST};
               r_next.frq_s[1] = {`RSP_PH_P1, `RSP_DIV_RST};
               r_next.frq_s[2] = {`RSP_PH_P2, `RSP_DIV_RST};
               r_next.frq_s[3] = {`RSP_PH_P3, `RSP_DIV_RST};
            end
            r_next.seq_ign = nv_stored_i ? nv_seq_i : `RSP_SEQ_RST;
            // Active copy is taken only here, never on a runtime write
            r_next.pin_a = r_next.pin_s;
            r_next.ccm_a = r_next.ccm_s;
            r_next.frq_a = r_next.frq_s;
            r_next.st = rsp_pkg::RSP_S_IDLE;
         end
         rsp_pkg::RSP_S_IDLE: begin
            r_next.step = 2'h0;
            if (seq_start_i) begin
               r_next.st = rsp_pkg::RSP_S_START;
            end else if (seq_stop_i) begin
               r_next.st = rsp_pkg::RSP_S_STOP;
            end
         end
         rsp_pkg::RSP_S_START: begin
            grp = group_at(r_reg.ord_s, share_det_i, r_reg.step, 1'b0);
            // Whole group turns on at once; first group never waits
            r_next.en = r_reg.en | grp;
            if (r_reg.step == `RSP_LAST_POS) begin
               r_next.st = rsp_pkg::RSP_S_IDLE;
            end else if (r_reg.seq_ign || &(power_good_i | ~grp)) begin
               r_next.step = r_reg.step + 2'h1;
            end
         end
         rsp_pkg::RSP_S_STOP: begin
            grp = group_at(r_reg.ord_s, share_det_i, r_reg.step, 1'b1);
            r_next.en = r_reg.en & ~grp;
            if (r_reg.step == `RSP_LAST_POS) begin
               r_next.st = rsp_pkg::RSP_S_IDLE;
            end else begin
               r_next.step = r_reg.step + 2'h1;
            end
         end
         default: begin
            r_next.st = rsp_pkg::RSP_S_LOAD;
         end
      endcase

      // ****************************************
      // Command access
      // ****************************************
      // Commands get neither ack nor error until the stored image is loaded
      if ((reg_wr_i || reg_rd_i) && r_reg.st != rsp_pkg::RSP_S_LOAD) begin
         r_next.ack = 1'b1;
         r_next.rdata = 8'h00;
         if (reg_cmd_i == `RSP_CMD_SEQ) begin
            // No page on this one
            if (reg_wr_i) begin
               r_next.seq_ign = reg_wdata_i[0];
            end
            r_next.rdata = {7'h00, r_reg.seq_ign};
         end else if (reg_cmd_i >= `RSP_CMD_PIN && reg_cmd_i <= `RSP_CMD_FREQ &&
                      page_ok) begin
            unique case (reg_cmd_i)
               `RSP_CMD_PIN: begin
                  if (reg_wr_i) begin
                     r_next.pin_s[pg] = reg_wdata_i[`RSP_SEL_BIT];
                  end
                  r_next.rdata = {7'h00, r_reg.pin_s[pg]};
               end
               `RSP_CMD_ORD: begin
                  if (reg_wr_i) begin
                     r_next.ord_s[pg] = reg_wdata_i[3:0];
                  end
                  r_next.rdata = {4'h0, r_reg.ord_s[pg]};
               end
               `RSP_CMD_MODE: begin
                  if (reg_wr_i) begin
                     r_next.ccm_s[pg] = reg_wdata_i[`RSP_CCM_BIT];
                  end
                  // Only master pages reach here while sharing
                  r_next.rdata = {6'h00, !pg[0] && share_det_i[pg[1]],
                                  r_reg.ccm_s[pg]};
               end
               default: begin
                  if (reg_wr_i) begin
                     r_next.frq_s[pg] = reg_wdata_i[6:0];
                  end
                  r_next.rdata = {1'b0, r_reg.frq_s[pg]};
               end
            endcase
         end else begin
            // Unknown command or invalid page
            r_next.err = 1'b1;
         end
      end

      // ****************************************
      // Pin and switching outputs
      // ****************************************
      for (int p = 0; p < 4; p++) begin
         s = src_of(p[1:0], share_det_i);
         // 5 uA source replaces the internal ramp in soft-start mode
         r_next.ss_src[p] = !r_reg.pin_a[s];
         r_next.pg_oe[p] = r_reg.pin_a[s];
         r_next.pg_out[p] = r_reg.pin_a[s] && power_good_i[p];
         r_next.ccm_o[p] = r_reg.ccm_a[s];
         dv = r_reg.frq_a[s][`RSP_DIV_LSB+:2];
         ph = r_reg.frq_a[s][`RSP_PH_LSB+:5];
         if (is_slave(p[1:0], share_det_i)) begin
            // Half a switching period after the master
            ph = ph + 5'(`RSP_HALF_TURN << dv);
         end
         r_next.div_o[p] = dv;
         r_next.ph_o[p] = ph;
      end
      r_next.busy = (r_next.st == rsp_pkg::RSP_S_START) ||
                    (r_next.st == rsp_pkg::RSP_S_STOP);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata_o = r_reg.rdata;
   assign reg_ack_o = r_reg.ack;
   assign reg_err_o = r_reg.err;
   assign rail_en_o = r_reg.en;
   assign softstart_src_en_o = r_reg.ss_src;
   assign output_pwrgood_pin_o = r_reg.pg_out;
   assign output_pwrgood_pin_oe_o = r_reg.pg_oe;
   assign conduction_mode_o = r_reg.ccm_o;
   assign clk_div_o = r_reg.div_o;
   assign phase_delay_o = r_reg.ph_o;
   assign seq_busy_o = r_reg.busy;

endmodule

// ### rsp_core_assertions.sv
// Port checker for the rail sequencer core
`timescale 1ns/1ns
module rsp_core_checker (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic seq_start_i,
   input wire logic seq_stop_i,
   input wire logic [3:0] power_good_i,
   input wire logic [1:0] share_det_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_ack_o,
   input wire logic reg_err_o,
   input wire logic [3:0] rail_en_o,
   input wire logic [3:0] softstart_src_en_o,
   input wire logic [3:0] output_pwrgood_pin_o,
   input wire logic [3:0] output_pwrgood_pin_oe_o,
   input wire logic [3:0] conduction_mode_o,
   input wire logic [7:0] clk_div_o,
   input wire logic [19:0] phase_delay_o,
   input wire logic seq_busy_o
);
   // ****************************************
   // Settle counter: load cycle must pass first
   // ****************************************
   logic [1:0] age_reg;
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         age_reg <= 2'h0;
      end else if (age_reg != 2'h3) begin
         age_reg <= age_reg + 2'h1;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   ack_has_req_a: assert property (reg_ack_o |-> $past(reg_wr_i | reg_rd_i))
      else $error("ack without request");
   req_gets_ack_a: assert property (age_reg == 2'h3 && (reg_wr_i || reg_rd_i) |=> reg_ack_o)
      else $error("access not answered");
   err_in_ack_a: assert property (reg_err_o |-> reg_ack_o)
      else $error("error outside ack");
   err_zero_data_a: assert property (reg_err_o |-> reg_rdata_o == 8'h00)
      else $error("refused access returned data");
   pin_follows_good_a: assert property (age_reg == 2'h3 |->
      ((output_pwrgood_pin_o ^ $past(power_good_i)) & output_pwrgood_pin_oe_o) == 4'h0)
      else $error("power good pin wrong");
   src_vs_pin_a: assert property (age_reg == 2'h3 |->
      (softstart_src_en_o ^ output_pwrgood_pin_oe_o) == 4'hF)
      else $error("pin role mismatch");
   // Sharing re-routes a slave to its master, so only a steady pair state must hold
   frozen_cfg_a: assert property (age_reg == 2'h3 && $past(share_det_i) == $past(share_det_i, 2)
      |-> $stable({conduction_mode_o, clk_div_o, phase_delay_o, output_pwrgood_pin_oe_o}))
      else $error("active setting changed at runtime");
   start_busy_a: assert property (age_reg == 2'h3 && seq_start_i && !seq_busy_o |=> seq_busy_o)
      else $error("start not taken");
   en_in_seq_a: assert property (age_reg == 2'h3 && (rail_en_o & ~$past(rail_en_o)) != 4'h0
      |-> $past(seq_busy_o))
      else $error("enable outside sequence");
   stop_clears_a: assert property (age_reg == 2'h3 && seq_stop_i && !seq_start_i && !seq_busy_o
      |-> ##[1:8] rail_en_o == 4'h0)
      else $error("stop sequence incomplete");
   cover property (reg_err_o);
   cover property (rail_en_o == 4'hF);
   cover property (seq_busy_o && rail_en_o == 4'h1);
endmodule

bind rsp_core rsp_core_checker u_rsp_core_checker (.clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .seq_start_i(seq_start_i),
   .seq_stop_i(seq_stop_i), .power_good_i(power_good_i), .share_det_i(share_det_i),
   .reg_rdata_o(reg_rdata_o),
   .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .rail_en_o(rail_en_o),
   .softstart_src_en_o(softstart_src_en_o), .output_pwrgood_pin_o(output_pwrgood_pin_o),
   .output_pwrgood_pin_oe_o(output_pwrgood_pin_oe_o), .conduction_mode_o(conduction_mode_o),
   .clk_div_o(clk_div_o), .phase_delay_o(phase_delay_o), .seq_busy_o(seq_busy_o));

// ### rsp_host.sv
// Host model issuing paged configuration accesses
`timescale 1ns/1ns
module rsp_host (
   input wire logic clk_sys_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_cmd_o,
   output logic [7:0] reg_page_o,
   output logic [7:0] reg_wdata_o
);
   initial {reg_wr_o, reg_rd_o, reg_cmd_o, reg_page_o, reg_wdata_o} = '0;
   // Called only while no sequence runs; released lines invert, never hold stale data
   task automatic access(input logic wr, input logic [7:0] cmd, page, data);
      {reg_wr_o, reg_rd_o, reg_cmd_o, reg_page_o, reg_wdata_o} = {wr, !wr, cmd, page, data};
      @(posedge clk_sys_i);
      #1;
      {reg_wr_o, reg_rd_o, reg_cmd_o, reg_page_o, reg_wdata_o} = {2'b00, ~cmd, ~page, ~data};
      @(posedge clk_sys_i);
      #1;
   endtask
endmodule

// ### testbench.sv
// Self-checking bench for the rail sequencer core
`timescale 1ns/1ns
module testbench;
   logic clk_sys_i, sys_rst_i, nv_stored_i, nv_seq_i, seq_start_i, seq_stop_i;
   logic [3:0] nv_pin_i, nv_ccm_i, power_good_i;
   logic [15:0] nv_ord_i;
   logic [27:0] nv_frq_i;
   logic [1:0] share_det_i;
   logic [7:0] r;
   logic [9:0] mon_e;
   logic [9:0] exp_q[$];
   wire logic reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, seq_busy_o;
   wire logic [7:0] reg_cmd_i, reg_page_i, reg_wdata_i, reg_rdata_o, clk_div_o;
   wire logic [3:0] rail_en_o, softstart_src_en_o, output_pwrgood_pin_o, conduction_mode_o;
   wire logic [3:0] output_pwrgood_pin_oe_o;
   wire logic [19:0] phase_delay_o;
   int num_errors = 0, num_checks = 0, cyc = 0;
   rsp_core u_rsp_core (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_cmd_i(reg_cmd_i), .reg_page_i(reg_page_i),
      .reg_wdata_i(reg_wdata_i), .nv_stored_i(nv_stored_i), .nv_pin_i(nv_pin_i),
      .nv_seq_i(nv_seq_i), .nv_ord_i(nv_ord_i), .nv_ccm_i(nv_ccm_i), .nv_frq_i(nv_frq_i),
      .share_det_i(share_det_i), .power_good_i(power_good_i), .seq_start_i(seq_start_i),
      .seq_stop_i(seq_stop_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
      .reg_err_o(reg_err_o), .rail_en_o(rail_en_o), .softstart_src_en_o(softstart_src_en_o),
      .output_pwrgood_pin_o(output_pwrgood_pin_o),
      .output_pwrgood_pin_oe_o(output_pwrgood_pin_oe_o), .conduction_mode_o(conduction_mode_o),
      .clk_div_o(clk_div_o), .phase_delay_o(phase_delay_o), .seq_busy_o(seq_busy_o));
   rsp_host u_rsp_host (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
      .reg_cmd_o(reg_cmd_i), .reg_page_o(reg_page_i), .reg_wdata_o(reg_wdata_i));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      chk("pending acks", 0, exp_q.size());
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Note is {data checked, error, data}
   task automatic acc(input logic wr, input logic [7:0] cmd, page, data, input logic [9:0] e);
      exp_q.push_back(e);
      u_rsp_host.access(wr, cmd, page, data);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic do_reset();
      sys_rst_i = 1;
      tick(12);
      sys_rst_i = 0;
      tick(3);
   endtask
   task automatic pulse(input logic stop);
      {seq_start_i, seq_stop_i} = {!stop, stop};
      tick(1);
      {seq_start_i, seq_stop_i} = 2'b00;
      tick(8);
   endtask
   initial begin
      clk_sys_i = 0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         test_done();
      end
   end
   always @(negedge clk_sys_i) begin
      if (reg_ack_o === 1'b1) begin
         mon_e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3FF;
         chk("reg_err_o", mon_e[8], reg_err_o);
         if (mon_e[9]) chk("reg_rdata_o", mon_e[7:0], reg_rdata_o);
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      {sys_rst_i, nv_stored_i, nv_seq_i, seq_start_i, seq_stop_i, share_det_i} = '0;
      {power_good_i, nv_pin_i, nv_ccm_i, nv_ord_i, nv_frq_i} = '0;
      void'($urandom(32'h03bfa544));
      do_reset();
      chk("conduction_mode_o", 4'hF, conduction_mode_o);
      chk("clk_div_o", 8'h00, clk_div_o);
      chk("phase_delay_o", 20'h18440, phase_delay_o);
      chk("softstart_src_en_o", 4'hF, softstart_src_en_o);
      for (int p = 0; p < 4; p++) begin
         acc(0, 8'hD3, 8'(p), 8'h00, 10'h200);
         acc(0, 8'hD5, 8'(p), 8'h00, 10'h200);
         acc(0, 8'hD6, 8'(p), 8'h00, 10'h201);
         acc(0, 8'hD7, 8'(p), 8'h00, {2'b10, 8'((p == 1) ? 8 : (p == 2) ? 4 : 4 * p)});
      end
      acc(0, 8'hD4, 8'h00, 8'h00, 10'h200);
      r = 8'($urandom());
      acc(1, 8'hD3, 8'h00, r, 10'h000);
      acc(0, 8'hD3, 8'h00, 8'h00, {2'b10, 7'h00, r[0]});
      acc(1, 8'hD6, 8'h01, r, 10'h000);
      acc(0, 8'hD6, 8'h01, 8'h00, {2'b10, 7'h00, r[0]});
      acc(1, 8'hD7, 8'h03, r, 10'h000);
      acc(0, 8'hD7, 8'h03, 8'h00, {3'b100, r[6:0]});
      acc(1, 8'hD5, 8'h02, r, 10'h000);
      acc(0, 8'hD5, 8'h02, 8'h00, {6'h20, r[3:0]});
      chk("active after writes", {4'hF, 4'hF, 20'h18440},
         {softstart_src_en_o, conduction_mode_o, phase_delay_o});
      acc(0, 8'hD8, 8'h00, 8'h00, 10'h300);
      acc(0, 8'hD5, 8'h04, 8'h00, 10'h300);
      share_det_i = 2'b11;
      acc(0, 8'hD6, 8'h00, 8'h00, 10'h203);
      acc(0, 8'hD6, 8'h02, 8'h00, 10'h203);
      acc(0, 8'hD6, 8'h01, 8'h00, 10'h300);
      share_det_i = 2'b00;
      {nv_stored_i, nv_pin_i, nv_ccm_i, nv_ord_i} = {1'b1, 4'h5, 4'h6, 16'h399C};
      nv_frq_i = 28'($urandom());
      do_reset();
      chk("pin role", 8'h5A, {output_pwrgood_pin_oe_o, softstart_src_en_o});
      chk("conduction_mode_o", 4'h6, conduction_mode_o);
      for (int p = 0; p < 4; p++) begin
         chk("clk_div_o", nv_frq_i[7 * p +: 2], clk_div_o[2 * p +: 2]);
         chk("phase_delay_o", nv_frq_i[7 * p + 2 +: 5], phase_delay_o[5 * p +: 5]);
      end
      share_det_i = 2'b01;
      tick(2);
      chk("slave follows", {1'b1, nv_ccm_i[0], nv_frq_i[1:0]},
         {output_pwrgood_pin_oe_o[1], conduction_mode_o[1], clk_div_o[3:2]});
      chk("slave phase", 5'(nv_frq_i[6:2] + (5'h02 << nv_frq_i[1:0])), phase_delay_o[9:5]);
      share_det_i = 2'b00;
      tick(2);
      acc(0, 8'hD5, 8'h01, 8'h00, 10'h209);
      power_good_i = 4'h3;
      tick(2);
      chk("pin value", 4'h1, output_pwrgood_pin_o & output_pwrgood_pin_oe_o);
      power_good_i = 4'h0;
      pulse(0);
      chk("first group only", 5'h11, {seq_busy_o, rail_en_o});
      power_good_i = 4'h1;
      tick(4);
      chk("shared position", 5'h17, {seq_busy_o, rail_en_o});
      power_good_i = 4'h7;
      tick(6);
      chk("all started", 5'h0F, {seq_busy_o, rail_en_o});
      pulse(1);
      chk("stopped", 5'h00, {seq_busy_o, rail_en_o});
      acc(1, 8'hD4, 8'h03, 8'h01, 10'h000);
      acc(0, 8'hD4, 8'h00, 8'h00, 10'h201);
      power_good_i = 4'h0;
      pulse(0);
      chk("ungated start", 5'h0F, {seq_busy_o, rail_en_o});
      pulse(1);
      chk("stopped again", 4'h0, rail_en_o);
      nv_seq_i = 1'b1;
      do_reset();
      acc(0, 8'hD4, 8'h00, 8'h00, 10'h201);
      test_done();
   end
endmodule
